// File: src/wdt_top.sv
// Purpose: watchdog timer core with avalon-mm register access
// Assumes: one clock, asynchronous active-low reset
// Notes:   writes and reads answer in one extra cycle
//
// The placing of the registers and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
module wdt_top
  import wdt_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // debug halt from the processor
  input  wire logic        debug_halted,
  // system outputs
  output logic             irq,
  output logic             nmi,
  output logic             sys_reset
);

  // ************************************************
  // registers
  // ************************************************
  logic [31:0]           reload_reg;
  logic [ctrl_width-1:0] ctrl_reg;
  logic [st_width-1:0]   status_reg;
  logic [st_width-1:0]   mask_reg;
  logic                  locked_reg;
  logic                  ack_reg;
  logic                  wait_reg;
  logic [31:0]           rdata_reg;
  logic                  irq_reg;
  logic                  nmi_reg;
  logic                  rst_reg;
  logic                  clr_load_reg;

  wdt_cfg_if cfg ();

  // ************************************************
  // bus decode
  // ************************************************
  // one wait cycle on every access keeps the read mux registered
  wire         req_w      = (avs_read || avs_write) && !ack_reg;
  wire         wr_w       = avs_write && !ack_reg;
  wire         full_wr_w  = wr_w && (avs_byteenable == 4'hf);
  wire         cfg_ok_w   = full_wr_w && !locked_reg;
  wire         wr_reload  = cfg_ok_w && (avs_address == reload_off);
  wire         wr_ctrl    = cfg_ok_w && (avs_address == ctrl_off);
  wire         wr_mask    = cfg_ok_w && (avs_address == mask_off);
  wire         wr_status  = full_wr_w && (avs_address == status_off);
  wire         wr_lock    = full_wr_w && (avs_address == lock_off);
  wire         running_w  = ctrl_reg[ctrl_en_bit];
  wire         int_en_w   = mask_reg[st_timeout_bit];
  wire         pending_w  = status_reg[st_timeout_bit];
  wire         clr_w      = wr_status && avs_writedata[st_timeout_bit];
  wire         second_w   = cfg.zero_evt && pending_w;
  wire         masked_w   = pending_w && int_en_w;
  wire [31:0]  ctrl_rd_w  = {{(32-ctrl_width){1'b0}}, ctrl_reg};
  wire [31:0]  st_rd_w    = {{(32-st_width){1'b0}}, status_reg};
  wire [31:0]  mask_rd_w  = {{(32-st_width){1'b0}}, mask_reg};
  wire [31:0]  lock_rd_w  = {31'h0000_0000, locked_reg};

  // read mux; unmapped offsets read as zero
  logic [31:0] rd_mux_w;
  always_comb begin
    case (avs_address)
      reload_off: rd_mux_w = reload_reg;
      value_off:  rd_mux_w = cfg.count;
      ctrl_off:   rd_mux_w = ctrl_rd_w;
      status_off: rd_mux_w = st_rd_w;
      mask_off:   rd_mux_w = mask_rd_w;
      lock_off:   rd_mux_w = lock_rd_w;
      default:    rd_mux_w = zero_word;
    endcase
  end

  // ************************************************
  // bus handshake
  // ************************************************
  // waitrequest has its own flop so the bus output never glitches
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_reg   <= 1'b0;
      wait_reg  <= 1'b1;
      rdata_reg <= zero_word;
    end else begin
      ack_reg   <= req_w;
      wait_reg  <= !req_w;
      rdata_reg <= (avs_read && !ack_reg) ? rd_mux_w : rdata_reg;
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata    = rdata_reg;

  // ************************************************
  // configuration
  // ************************************************
  // enable bit is sticky: only reset clears it, so a hung task cannot stop it
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reload_reg <= reload_reset;
      ctrl_reg   <= '0;
      mask_reg   <= '0;
    end else begin
      if (wr_reload)
        reload_reg <= avs_writedata;
      if (wr_ctrl)
        ctrl_reg <= avs_writedata[ctrl_width-1:0] |
                    {{(ctrl_width-1){1'b0}}, running_w};
      if (wr_ctrl && avs_writedata[ctrl_en_bit])
        mask_reg[st_timeout_bit] <= 1'b1;
      else if (wr_mask)
        mask_reg[st_timeout_bit] <= avs_writedata[st_timeout_bit] | running_w;
    end
  end

  // lock: key word unlocks, any other value locks
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      locked_reg <= 1'b0;
    else if (wr_lock)
      locked_reg <= (avs_writedata != unlock_key);
  end

  // ************************************************
  // counter control
  // ************************************************
  // a clear reloads the counter one cycle later
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      clr_load_reg <= 1'b0;
    else
      clr_load_reg <= clr_w && pending_w && running_w;
  end

  assign cfg.enable   = running_w;
  assign cfg.stall_en = ctrl_reg[ctrl_stall_bit];
  assign cfg.halted   = debug_halted;
  assign cfg.load_val = wr_reload ? avs_writedata : reload_reg;
  // a stopped counter takes the reload too, so enable starts from it
  assign cfg.load_now = wr_reload || clr_load_reg;

  wdt_counter u_counter (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .cfg      (cfg)
  );

  // ************************************************
  // status, interrupt and reset
  // ************************************************
  // set wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      status_reg <= '0;
    else if (cfg.zero_evt && int_en_w)
      status_reg[st_timeout_bit] <= 1'b1;
    else if (clr_w)
      status_reg[st_timeout_bit] <= 1'b0;
  end

  // reset stays latched until the system resets the block
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_reg <= 1'b0;
      nmi_reg <= 1'b0;
      rst_reg <= 1'b0;
    end else begin
      irq_reg <= masked_w && !ctrl_reg[ctrl_nmi_bit];
      nmi_reg <= masked_w && ctrl_reg[ctrl_nmi_bit];
      if (second_w && ctrl_reg[ctrl_rsten_bit])
        rst_reg <= 1'b1;
    end
  end

  assign irq       = irq_reg;
  assign nmi       = nmi_reg;
  assign sys_reset = rst_reg;

  // ************************************************
  // checks
  // ************************************************
  sequence wr_taken_s;
    avs_write && !avs_waitrequest;
  endsequence

  sequence second_timeout_s;
    cfg.zero_evt && pending_w;
  endsequence

  reset_fire_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    second_timeout_s ##0 ctrl_reg[ctrl_rsten_bit] |=> sys_reset)
    else $error("missing system reset");
  reset_gate_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(sys_reset) |-> $past(ctrl_reg[ctrl_rsten_bit]) && $past(second_w))
    else $error("reset without enable");
  lock_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    locked_reg && !wr_lock |=> $stable(reload_reg) && $stable(ctrl_reg))
    else $error("write passed the lock");
  unlock_open_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_lock && avs_writedata == unlock_key |=> !locked_reg)
    else $error("unlock failed");
  enable_int_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_ctrl && avs_writedata[ctrl_en_bit] |=> running_w && int_en_w)
    else $error("enable did not start interrupt");
  int_route_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    masked_w && !ctrl_reg[ctrl_nmi_bit] ##1 $stable(ctrl_reg) |-> irq && !nmi)
    else $error("interrupt routed wrong");
  clear_reload_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    clr_load_reg && !wr_reload |=> cfg.count == $past(reload_reg))
    else $error("no reload after clear");
  zero_load_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_reload && running_w && avs_writedata == zero_word |=> cfg.zero_evt)
    else $error("zero reload gave no event");
  read_reload_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    avs_read && !ack_reg && avs_address == reload_off |=> avs_readdata == $past(reload_reg))
    else $error("reload readback wrong");
  write_ack_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    avs_write && avs_waitrequest |=> !avs_waitrequest)
    else $error("write not answered");

  // ************************************************
  // bus and readback checks
  // ************************************************
  // one wait state, then the slave drops back to waiting
  ack_single_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_taken_s |=> avs_waitrequest)
    else $error("answer held too long");
  read_ack_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("read not answered");
  idle_wait_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !avs_read && !avs_write |=> avs_waitrequest)
    else $error("answer without request");

  // read data is the mux value of the first request cycle, the wait cycle before the read is taken
  count_read_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    avs_read && !ack_reg && avs_address == value_off
      |=> avs_readdata == $past(cfg.count))
    else $error("count readback wrong");
  run_read_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    avs_read && !ack_reg && avs_address == ctrl_off
      |=> avs_readdata[ctrl_en_bit] == $past(running_w))
    else $error("running status wrong");
  lock_read_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    avs_read && !ack_reg && avs_address == lock_off
      |=> avs_readdata == $past(lock_rd_w))
    else $error("lock state readback wrong");
  status_read_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    avs_read && !ack_reg && avs_address == status_off
      |=> avs_readdata[st_timeout_bit] == $past(pending_w))
    else $error("pending readback wrong");

  // ************************************************
  // configuration checks
  // ************************************************
  // reload write, lock and enable stickiness
  reload_wr_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_reload |=> reload_reg == $past(avs_writedata))
    else $error("reload write lost");
  lock_set_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_lock && avs_writedata != unlock_key |=> locked_reg)
    else $error("lock not taken");
  lock_mask_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    locked_reg && !wr_lock |=> $stable(mask_reg))
    else $error("mask written while locked");
  en_sticky_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    running_w |=> running_w)
    else $error("counter enable dropped");
  mask_on_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    running_w |-> int_en_w)
    else $error("interrupt enable off while running");

  // a partial write is answered but changes nothing
  partial_wr_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    avs_write && avs_byteenable != 4'hf
      |=> $stable(reload_reg) && $stable(ctrl_reg) && $stable(mask_reg))
    else $error("partial write took effect");

  // ************************************************
  // counter, interrupt and reset checks
  // ************************************************
  // counter loading from the register side
  reload_live_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_reload && running_w |=> cfg.count == $past(avs_writedata))
    else $error("live reload not loaded");
  stopped_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !running_w && !cfg.load_now |=> $stable(cfg.count))
    else $error("count moved while stopped");
  stopped_zero_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_reload && !running_w |=> !cfg.zero_evt)
    else $error("event while stopped");

  sequence zero_hit_s;
    cfg.zero_evt && int_en_w;
  endsequence

  sequence clear_taken_s;
    clr_w && pending_w && running_w;
  endsequence

  // event, then pending, then the interrupt line
  pend_int_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    zero_hit_s |=> pending_w ##1 (irq || nmi))
    else $error("timeout gave no interrupt");
  clear_pend_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    clr_w && !(cfg.zero_evt && int_en_w) |=> !pending_w)
    else $error("pending not cleared");
  clear_load_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    clear_taken_s |=> cfg.load_now)
    else $error("clear did not reload");
  nmi_route_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    masked_w && ctrl_reg[ctrl_nmi_bit] ##1 $stable(ctrl_reg) |-> nmi && !irq)
    else $error("nmi routed wrong");
  irq_quiet_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !masked_w |=> !irq && !nmi)
    else $error("interrupt without pending");

  // system reset gating and latching
  no_reset_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !ctrl_reg[ctrl_rsten_bit] && !sys_reset |=> !sys_reset)
    else $error("reset while disabled");
  reset_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    sys_reset |=> sys_reset)
    else $error("system reset dropped");

endmodule : wdt_top

// File: shared/wdt_pkg.sv
// Purpose: constants for the watchdog timer core
// Assumes: avalon-mm slave, 32-bit data, word addressing by byte offset
// Notes:   all offsets are byte addresses of aligned words
package wdt_pkg;

  // ************************************************
  // register offsets
  // ************************************************
  localparam logic [7:0] reload_off  = 8'h00;
  localparam logic [7:0] value_off   = 8'h04;
  localparam logic [7:0] ctrl_off    = 8'h08;
  localparam logic [7:0] status_off  = 8'h0c;
  localparam logic [7:0] mask_off    = 8'h10;
  localparam logic [7:0] lock_off    = 8'h14;

  // ************************************************
  // control fields
  // ************************************************
  localparam int ctrl_en_bit    = 0;
  localparam int ctrl_rsten_bit = 1;
  localparam int ctrl_nmi_bit   = 2;
  localparam int ctrl_stall_bit = 3;
  localparam int ctrl_width     = 4;

  // status and mask fields
  localparam int st_timeout_bit = 0;
  localparam int st_width       = 1;

  // lock: writing the key unlocks, any other value locks
  localparam logic [31:0] unlock_key   = 32'h1acc_e551;
  localparam logic [31:0] reload_reset = 32'hffff_ffff;
  localparam logic [31:0] zero_word    = 32'h0000_0000;
  localparam logic [31:0] one_word     = 32'h0000_0001;

endpackage : wdt_pkg

// File: shared/wdt_cfg_if.sv
// Purpose: configuration bundle from register file to counter
// Assumes: single clock domain
// Notes:   settings driven by the top, read by the counter; count and zero_evt driven back by the counter
`timescale 1ns/1ps
interface wdt_cfg_if;
  logic        enable;
  logic        stall_en;
  logic        load_now;
  logic [31:0] load_val;
  logic        halted;
  logic        zero_evt;
  logic [31:0] count;

  modport ctl (output enable, output stall_en, output load_now, output load_val,
               output halted, input zero_evt, input count);
  modport cnt (input enable, input stall_en, input load_now, input load_val,
               input halted, output zero_evt, output count);
endinterface : wdt_cfg_if

// File: src/wdt_counter.sv
// Purpose: 32-bit down counter of the watchdog
// Assumes: load_now has priority over counting
// Notes:   zero_evt pulses one cycle when count hits zero, but stays high while counting on a zero reload
`timescale 1ns/1ps
module wdt_counter
  import wdt_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // configuration
  wdt_cfg_if.cnt    cfg
);

  logic [31:0] count_reg;
  logic        zero_reg;
  wire         run_w  = cfg.enable && !(cfg.stall_en && cfg.halted);
  wire         at_zero = (count_reg == zero_word);

  // ************************************************
  // counting
  // ************************************************
  // a zero reload raises the event right away from the load value, but only while enabled
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= reload_reset;
      zero_reg  <= 1'b0;
    end else if (cfg.load_now) begin
      count_reg <= cfg.load_val;
      zero_reg  <= cfg.enable && (cfg.load_val == zero_word);
    end else if (run_w) begin
      count_reg <= at_zero ? cfg.load_val : count_reg - one_word;
      zero_reg  <= at_zero;
    end else begin
      zero_reg  <= 1'b0;
    end
  end

  assign cfg.count    = count_reg;
  assign cfg.zero_evt = zero_reg;

  // ************************************************
  // checks
  // ************************************************
  stall_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cfg.enable && cfg.stall_en && cfg.halted && !cfg.load_now)
      |=> (count_reg == $past(count_reg)))
    else $error("count moved during debug halt");
  count_dec_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cfg.enable && !cfg.stall_en && !cfg.load_now && !at_zero)
      |=> (count_reg == $past(count_reg) - one_word))
    else $error("count did not decrement");
  zero_reload_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (run_w && !cfg.load_now && at_zero)
      |=> (count_reg == $past(cfg.load_val)) && zero_reg)
    else $error("no reload at zero");

endmodule : wdt_counter

// File: sim/wdt_sys_model.sv
// Purpose: stand-in for the interrupt controller and the system reset logic
// Assumes: irq, nmi and sys_reset are levels from the watchdog
// Notes:   counts rising edges; software clearing goes through the bench
`timescale 1ns/1ps
module wdt_sys_model (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // watchdog outputs
  input  wire logic irq,
  input  wire logic nmi,
  input  wire logic sys_reset,
  // observed events
  output int        irq_count,
  output int        nmi_count,
  output logic      reset_seen
);
  logic irq_reg;
  logic nmi_reg;
  // a level held high counts once, so a stuck line shows up as one event
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_reg    <= 1'b0;
      nmi_reg    <= 1'b0;
      irq_count  <= 0;
      nmi_count  <= 0;
      reset_seen <= 1'b0;
    end else begin
      irq_reg <= irq;
      nmi_reg <= nmi;
      if (irq && !irq_reg) irq_count <= irq_count + 1;
      if (nmi && !nmi_reg) nmi_count <= nmi_count + 1;
      if (sys_reset) reset_seen <= 1'b1;
    end
  end
endmodule : wdt_sys_model

// File: sim/watchdog_timer_core_tb.sv
// Purpose: self-checking bench for the watchdog timer core
// Assumes: one wait state per access, enable only cleared by reset
// Notes:   each test starts from a fresh reset
`timescale 1ns/1ps
module watchdog_timer_core_tb;
  import wdt_pkg::*;
  logic        core_clk, reset_n, avs_read, avs_write, avs_waitrequest;
  logic        debug_halted, irq, nmi, sys_reset, reset_seen;
  logic [7:0]  avs_address;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd, rd2;
  int          irq_count, nmi_count, fails, tests_run;

  always #2.5 core_clk = !core_clk;

  wdt_top i_dut (.core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .debug_halted(debug_halted), .irq(irq),
    .nmi(nmi), .sys_reset(sys_reset));
  wdt_sys_model i_sys (.core_clk(core_clk), .reset_n(reset_n), .irq(irq), .nmi(nmi),
    .sys_reset(sys_reset), .irq_count(irq_count), .nmi_count(nmi_count),
    .reset_seen(reset_seen));

  // ************************************************
  // bus and check tasks
  // ************************************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                     output logic [31:0] q);
    int n;
    @(posedge core_clk);
    avs_address   <= addr;
    avs_writedata <= data;
    avs_write     <= wr;
    avs_read      <= !wr;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (avs_waitrequest !== 1'b0) begin
      fails++;
      final_report();
    end
    // read data is taken at the edge that ends the wait
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    logic [31:0] q;
    bus(1'b1, addr, data, q);
  endtask : wr

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, addr, 32'h0000_0000, q);
    check(q, exp);
  endtask : rd_chk

  function automatic logic pick(input int sel);
    return (sel == 0) ? irq : (sel == 1) ? nmi : sys_reset;
  endfunction : pick

  // bounded wait; running out ends the run as a failure
  task automatic wait_hi(input int sel, input int bound);
    int n;
    n = 0;
    while (pick(sel) !== 1'b1 && n < bound) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= bound) begin
      fails++;
      final_report();
    end
  endtask : wait_hi

  task automatic do_reset(input string name);
    $display("test %0s done", name);
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
  endtask : do_reset

  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    core_clk       = 1'b0;
    reset_n        = 1'b0;
    avs_address    = 8'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'hf;
    debug_halted   = 1'b0;
    do_reset("start");
    rd_chk(reload_off, reload_reset);
    rd_chk(value_off, reload_reset);
    rd_chk(lock_off, zero_word);
    rd_chk(ctrl_off, zero_word);
    rd_chk(8'h40, zero_word);
    wr(reload_off, 32'h0000_0020);
    rd_chk(reload_off, 32'h0000_0020);
    wr(ctrl_off, 32'h0000_0003);
    rd_chk(ctrl_off, 32'h0000_0003);
    bus(1'b0, value_off, zero_word, rd);
    bus(1'b0, value_off, zero_word, rd2);
    check(rd2 < rd, 1'b1);
    wait_hi(0, 40);
    rd_chk(status_off, one_word);
    check(irq_count, 1);
    wait_hi(2, 50);
    @(negedge core_clk);
    check(reset_seen, 1'b1);
    do_reset("second_timeout");
    wr(reload_off, 32'h0000_0040);
    wr(ctrl_off, 32'h0000_0001);
    wait_hi(0, 80);
    wr(status_off, one_word);
    bus(1'b0, value_off, zero_word, rd);
    check(rd > 32'h0000_0030 && rd <= 32'h0000_0040, 1'b1);
    check(irq, 1'b0);
    wait_hi(0, 80);
    repeat (80) @(negedge core_clk);
    check(sys_reset, 1'b0);
    do_reset("clear_pending");
    wr(ctrl_off, 32'h0000_0001);
    wr(reload_off, 32'h0000_0100);
    bus(1'b0, value_off, zero_word, rd);
    check(rd > 32'h0000_00e0 && rd <= 32'h0000_0100, 1'b1);
    check(irq, 1'b0);
    wr(reload_off, zero_word);
    wait_hi(0, 5);
    do_reset("reload_live");
    wr(reload_off, 32'h0000_0030);
    wr(ctrl_off, 32'h0000_0005);
    wait_hi(1, 60);
    check(irq, 1'b0);
    @(negedge core_clk);
    check(nmi_count, 1);
    wr(status_off, one_word);
    repeat (3) @(negedge core_clk);
    check(nmi, 1'b0);
    do_reset("nmi_type");
    wr(lock_off, zero_word);
    rd_chk(lock_off, one_word);
    wr(reload_off, 32'h0000_0055);
    rd_chk(reload_off, reload_reset);
    wr(ctrl_off, 32'h0000_0001);
    rd_chk(ctrl_off, zero_word);
    wr(lock_off, unlock_key);
    rd_chk(lock_off, zero_word);
    wr(reload_off, 32'h0000_0055);
    rd_chk(reload_off, 32'h0000_0055);
    avs_byteenable <= 4'h3;
    wr(reload_off, 32'h0000_0077);
    avs_byteenable <= 4'hf;
    rd_chk(reload_off, 32'h0000_0055);
    do_reset("lock");
    wr(ctrl_off, 32'h0000_0009);
    debug_halted <= 1'b1;
    repeat (3) @(posedge core_clk);
    bus(1'b0, value_off, zero_word, rd);
    bus(1'b0, value_off, zero_word, rd2);
    check(rd2, rd);
    debug_halted <= 1'b0;
    bus(1'b0, value_off, zero_word, rd2);
    check(rd2 < rd, 1'b1);
    wr(ctrl_off, 32'h0000_0001);
    debug_halted <= 1'b1;
    repeat (3) @(posedge core_clk);
    bus(1'b0, value_off, zero_word, rd);
    bus(1'b0, value_off, zero_word, rd2);
    check(rd2 < rd, 1'b1);
    do_reset("debug_stall");
    final_report();
  end
endmodule : watchdog_timer_core_tb
